// *** verilog/slot_pkg.sv ***
package slot_pkg;
    // Register map
    localparam logic [7:0]  SLOT_OFF    = 8'hD8;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Control half, bits 12:0 stored, 15:13 read zero
    localparam int          CTRL_W      = 13;
    localparam logic [12:0] CTRL_RESET  = 13'h01C0;
    localparam int          ATTN_LSB    = 6;
    localparam int          PWR_LSB     = 8;
    localparam int          PWR_OFF_BIT = 10;
    localparam int          LATCH_BIT   = 11;

    // Event flags: button, fault, latch, presence, command, link
    localparam int          NEV         = 6;
    localparam int          EV_LATCH    = 2;
    localparam int          EV_CMD      = 4;
    localparam int          EV_STAT_BIT [NEV] = '{16, 17, 18, 19, 20, 24};
    localparam int          EV_EN_BIT   [NEV] = '{0, 1, 2, 3, 4, 12};
    localparam logic [5:0]  EV_W1C      = 6'h3B;
    localparam int          HP_EN_BIT   = 5;
    localparam int          LATCH_ST_BIT = 21;
    localparam int          PRES_ST_BIT = 22;

    // Indicator message codes: {power, field}
    localparam logic        MSG_ATTN    = 1'b0;
    localparam logic        MSG_PWR     = 1'b1;

    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_SEND = 1'b1
    } tx_state_t;
endpackage

// *** verilog/slot_sense_if.sv ***
interface slot_sense_if;
    logic latch_open;
    logic presence;
    logic latch_chg;
    logic pres_chg;
    logic link_chg;

    modport detect (output latch_open, presence, latch_chg, pres_chg,
                    link_chg);
    modport core   (input  latch_open, presence, latch_chg, pres_chg,
                    link_chg);
endinterface

// *** verilog/slot_change_detect.sv ***
module slot_change_detect (
    // Clock and reset
    input  wire logic   aclk,
    input  wire logic   aresetn,
    // Live slot levels
    input  wire logic   latch_open,
    input  wire logic   card_present,
    input  wire logic   slot_implemented,
    input  wire logic   link_active,
    // Toward the register core
    slot_sense_if.detect sense
);
    logic primed_r;
    logic latch_r;
    logic pres_r;
    logic link_r;
    logic pres_eff;

    // Without a slot, presence always reads as present
    assign pres_eff         = card_present | ~slot_implemented;
    assign sense.latch_open = latch_open;
    assign sense.presence   = pres_eff;
    // No change is reported on the first sample after reset
    assign sense.latch_chg  = primed_r & (latch_r != latch_open);
    assign sense.pres_chg   = primed_r & (pres_r != pres_eff);
    assign sense.link_chg   = primed_r & (link_r != link_active);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            primed_r <= 1'b0;
            latch_r  <= 1'b0;
            pres_r   <= 1'b0;
            link_r   <= 1'b0;
        end else begin
            primed_r <= 1'b1;
            latch_r  <= latch_open;
            pres_r   <= pres_eff;
            link_r   <= link_active;
        end
    end
endmodule

// *** verilog/indicator_msg_tx.sv ***
module indicator_msg_tx (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Requests from field writes
    input  wire logic       attn_req,
    input  wire logic       pwr_req,
    input  wire logic [1:0] attn_field,
    input  wire logic [1:0] pwr_field,
    output logic            busy,
    // Message port
    output logic            msg_valid,
    output logic [2:0]      msg_code,
    input  wire logic       msg_ready
);
    slot_pkg::tx_state_t state_r;
    logic                attn_pend_r;
    logic                pwr_pend_r;
    logic [2:0]          code_r;
    logic                take_attn;
    logic                take_pwr;

    assign take_attn = (state_r == slot_pkg::TX_IDLE) & attn_pend_r;
    assign take_pwr  = (state_r == slot_pkg::TX_IDLE) & ~attn_pend_r
                       & pwr_pend_r;
    assign msg_valid = (state_r == slot_pkg::TX_SEND);
    assign msg_code  = code_r;
    assign busy      = attn_pend_r | pwr_pend_r | msg_valid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r     <= slot_pkg::TX_IDLE;
            attn_pend_r <= 1'b0;
            pwr_pend_r  <= 1'b0;
            code_r      <= 3'h0;
        end else begin
            // A new write while pending keeps the request
            attn_pend_r <= attn_req | (attn_pend_r & ~take_attn);
            pwr_pend_r  <= pwr_req | (pwr_pend_r & ~take_pwr);
            unique case (state_r)
                slot_pkg::TX_IDLE: begin
                    if (take_attn) begin
                        code_r  <= {slot_pkg::MSG_ATTN, attn_field};
                        state_r <= slot_pkg::TX_SEND;
                    end else if (take_pwr) begin
                        code_r  <= {slot_pkg::MSG_PWR, pwr_field};
                        state_r <= slot_pkg::TX_SEND;
                    end
                end
                slot_pkg::TX_SEND: begin
                    if (msg_ready)
                        state_r <= slot_pkg::TX_IDLE;
                end
            endcase
        end
    end
endmodule

// *** verilog/hotplug_slot_control_status.sv ***
module hotplug_slot_control_status #(
    parameter int AW = 8
) (
    // Clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // AXI4-Lite write address
    input  wire logic [AW-1:0] awaddr,
    input  wire logic          awvalid,
    output logic               awready,
    // AXI4-Lite write data
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    input  wire logic          wvalid,
    output logic               wready,
    // AXI4-Lite write response
    output logic [1:0]         bresp,
    output logic               bvalid,
    input  wire logic          bready,
    // AXI4-Lite read address
    input  wire logic [AW-1:0] araddr,
    input  wire logic          arvalid,
    output logic               arready,
    // AXI4-Lite read data
    output logic [31:0]        rdata,
    output logic [1:0]         rresp,
    output logic               rvalid,
    input  wire logic          rready,
    // Slot sensors and button
    input  wire logic          attn_button_pressed,
    input  wire logic          power_fault_detected,
    input  wire logic          latch_open,
    input  wire logic          card_present,
    input  wire logic          slot_implemented,
    input  wire logic          link_active,
    // Slot controls
    output logic               power_off,
    output logic               electromechanical_latch_control,
    output logic               hotplug_irq,
    // Indicator messages
    output logic               msg_valid,
    output logic [2:0]         msg_code,
    input  wire logic          msg_ready
);
    if (AW < 8) begin : g_aw_check
        $error("AW must be at least 8");
    end

    // Register byte address at the bus width
    localparam logic [AW-1:0] OFF_A = AW'(slot_pkg::SLOT_OFF);

    // Write channel state
    logic                awready_r;
    logic                wready_r;
    logic                bvalid_r;
    logic [1:0]          bresp_r;
    logic [AW-1:0]       awaddr_r;
    logic [31:0]         wdata_r;
    logic [3:0]          wstrb_r;
    // Read channel state
    logic                arready_r;
    logic                rvalid_r;
    logic [1:0]          rresp_r;
    logic [31:0]         rdata_r;
    // Register state
    logic [12:0]         ctrl_r;
    logic [12:0]         ctrl_nxt;
    logic [5:0]          ev_flag_r;
    logic [5:0]          ev_flag_nxt;
    logic                cmd_busy_r;
    logic                irq_r;
    // Decode and events
    logic                aw_take;
    logic                w_take;
    logic                ar_take;
    logic                do_write;
    logic                wr_hit;
    logic                rd_hit;
    logic                ctrl_wr;
    logic                attn_wr;
    logic                pwr_wr;
    logic                cmd_done;
    logic                tx_busy;
    logic [5:0]          ev_set;
    logic [5:0]          ev_clr;
    logic [5:0]          ev_en;
    logic [31:0]         rd_word;

    slot_sense_if sense ();

    slot_change_detect u_detect (
        .aclk             (aclk),
        .aresetn          (aresetn),
        .latch_open       (latch_open),
        .card_present     (card_present),
        .slot_implemented (slot_implemented),
        .link_active      (link_active),
        .sense            (sense.detect)
    );

    indicator_msg_tx u_msg (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .attn_req   (attn_wr),
        .pwr_req    (pwr_wr),
        .attn_field (ctrl_r[slot_pkg::ATTN_LSB +: 2]),
        .pwr_field  (ctrl_r[slot_pkg::PWR_LSB +: 2]),
        .busy       (tx_busy),
        .msg_valid  (msg_valid),
        .msg_code   (msg_code),
        .msg_ready  (msg_ready)
    );

    // Bus handshakes and decode
    assign aw_take  = awvalid & awready_r;
    assign w_take   = wvalid & wready_r;
    assign ar_take  = arvalid & arready_r;
    assign do_write = ~awready_r & ~wready_r & ~bvalid_r;
    assign wr_hit   = awaddr_r[AW-1:2] == OFF_A[AW-1:2];
    assign rd_hit   = araddr[AW-1:2] == OFF_A[AW-1:2];
    assign ctrl_wr  = do_write & wr_hit & (wstrb_r[0] | wstrb_r[1]);
    // Field writes raise indicator messages
    assign attn_wr  = do_write & wr_hit & wstrb_r[0];
    assign pwr_wr   = do_write & wr_hit & wstrb_r[1];

    // Byte-lane writes into the control half
    assign ctrl_nxt = {wstrb_r[1] ? wdata_r[12:8] : ctrl_r[12:8],
                       wstrb_r[0] ? wdata_r[7:0] : ctrl_r[7:0]};

    // Command completes once its messages have left
    assign cmd_done = cmd_busy_r & ~tx_busy & ~ctrl_wr;

    // Event sources in flag order
    assign ev_set = {sense.link_chg,
                     cmd_done,
                     sense.pres_chg,
                     sense.latch_chg,
                     power_fault_detected,
                     attn_button_pressed};

    for (genvar i = 0; i < slot_pkg::NEV; i++) begin : g_ev
        assign ev_clr[i] = do_write & wr_hit & slot_pkg::EV_W1C[i]
                           & wstrb_r[slot_pkg::EV_STAT_BIT[i] / 8]
                           & wdata_r[slot_pkg::EV_STAT_BIT[i]];
        // A set in the clearing cycle wins
        assign ev_flag_nxt[i] = ev_set[i] | (ev_flag_r[i] & ~ev_clr[i]);
        // Per-event enables
        assign ev_en[i] =
            ctrl_r[slot_pkg::EV_EN_BIT[i]];
    end

    // Read word assembly
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_word[12:0] = ctrl_r;
        for (int i = 0; i < slot_pkg::NEV; i++) begin
            rd_word[slot_pkg::EV_STAT_BIT[i]] = ev_flag_r[i];
        end
        rd_word[slot_pkg::LATCH_ST_BIT] = sense.latch_open;
        rd_word[slot_pkg::PRES_ST_BIT]  = sense.presence;
        if (!rd_hit)
            rd_word = 32'h0000_0000;
    end

    // Write channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= slot_pkg::RESP_OKAY;
            awaddr_r  <= '0;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end else begin
            if (aw_take) begin
                awready_r <= 1'b0;
                awaddr_r  <= awaddr;
            end
            if (w_take) begin
                wready_r <= 1'b0;
                wdata_r  <= wdata;
                wstrb_r  <= wstrb;
            end
            if (do_write) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_hit ? slot_pkg::RESP_OKAY
                                   : slot_pkg::RESP_SLVERR;
            end
            if (bvalid_r && bready) begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // Read channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rresp_r   <= slot_pkg::RESP_OKAY;
            rdata_r   <= 32'h0000_0000;
        end else if (ar_take) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_word;
            rresp_r   <= rd_hit ? slot_pkg::RESP_OKAY
                                : slot_pkg::RESP_SLVERR;
        end else if (rvalid_r && rready) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // Control half
    always_ff @(posedge aclk) begin
        if (!aresetn)
            ctrl_r <= slot_pkg::CTRL_RESET;
        else if (ctrl_wr)
            ctrl_r <= ctrl_nxt;
    end

    // Status flags, command tracking and interrupt
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_flag_r  <= 6'h00;
            cmd_busy_r <= 1'b0;
            irq_r      <= 1'b0;
        end else begin
            ev_flag_r  <= ev_flag_nxt;
            cmd_busy_r <= ctrl_wr | (cmd_busy_r & ~cmd_done);
            irq_r      <= ctrl_r[slot_pkg::HP_EN_BIT]
                          & |(ev_flag_r & ev_en);
        end
    end

    assign awready     = awready_r;
    assign wready      = wready_r;
    assign bvalid      = bvalid_r;
    assign bresp       = bresp_r;
    assign arready     = arready_r;
    assign rvalid      = rvalid_r;
    assign rresp       = rresp_r;
    assign rdata       = rdata_r;
    assign hotplug_irq = irq_r;
    assign power_off   = ctrl_r[slot_pkg::PWR_OFF_BIT];
    assign electromechanical_latch_control = ctrl_r[slot_pkg::LATCH_BIT];
endmodule

// *** verification/slot_chk.sv ***
module slot_chk #(
    parameter int AW = 8
) (
    // Clock and reset
    input wire logic          aclk,
    input wire logic          aresetn,
    // Register bus
    input wire logic [AW-1:0] awaddr,
    input wire logic          awvalid,
    input wire logic          awready,
    input wire logic [31:0]   wdata,
    input wire logic [3:0]    wstrb,
    input wire logic          wvalid,
    input wire logic          wready,
    input wire logic [1:0]    bresp,
    input wire logic          bvalid,
    input wire logic          bready,
    input wire logic [AW-1:0] araddr,
    input wire logic          arvalid,
    input wire logic          arready,
    input wire logic [31:0]   rdata,
    input wire logic [1:0]    rresp,
    input wire logic          rvalid,
    input wire logic          rready,
    // Slot side
    input wire logic          slot_implemented,
    input wire logic          power_off,
    input wire logic          msg_valid,
    input wire logic [2:0]    msg_code,
    input wire logic          msg_ready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wr_take;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence rd_take;
        arvalid && arready;
    endsequence

    chk_write_answer: assert property (wr_take |-> ##2 bvalid)
        else $error("write response not on time");
    chk_write_unmapped: assert property (
        wr_take ##0 ((awaddr >> 2) != (AW'(slot_pkg::SLOT_OFF) >> 2))
        |-> ##2 bresp == slot_pkg::RESP_SLVERR)
        else $error("unmapped write not refused");
    chk_write_refuse: assert property (bvalid |-> !awready && !wready)
        else $error("write accepted while response pending");
    chk_resp_hold: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    chk_read_answer: assert property (rd_take |=> rvalid)
        else $error("read data not on time");
    chk_read_unmapped: assert property (
        rd_take ##0 ((araddr >> 2) != (AW'(slot_pkg::SLOT_OFF) >> 2))
        |=> rresp == slot_pkg::RESP_SLVERR && rdata == 32'h0)
        else $error("unmapped read not refused");
    chk_read_hold: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    chk_presence_forced: assert property (
        (!slot_implemented)[*3] ##0 rd_take ##0 (araddr == slot_pkg::SLOT_OFF)
        |=> rdata[22])
        else $error("presence not forced without slot");
    chk_power_ctl: assert property (
        wr_take ##0 (awaddr == slot_pkg::SLOT_OFF && wstrb[1])
        |-> ##2 power_off == $past(wdata[10], 2))
        else $error("power control output wrong");
    chk_msg_hold: assert property (
        msg_valid && !msg_ready |=> msg_valid && $stable(msg_code))
        else $error("indicator message dropped early");
endmodule

bind hotplug_slot_control_status slot_chk #(.AW(AW)) i_chk (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .slot_implemented, .power_off, .msg_valid,
    .msg_code, .msg_ready
);

// *** verification/slot_partner.sv ***
module slot_partner (
    // Clock
    input  wire logic       aclk,
    // Indicator message port
    input  wire logic       msg_valid,
    input  wire logic [2:0] msg_code,
    output logic            msg_ready,
    // Stall select
    input  wire logic       slow
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] codes [$];
    int         wait_n;
    initial begin
        msg_ready = 1'h0;
        wait_n = 0;
    end
    // Take a message next cycle, or after four stalled cycles
    always @(posedge aclk) begin
        if (msg_valid && msg_ready) begin
            codes.push_back(msg_code);
            msg_ready <= 1'h0;
            wait_n    <= 0;
        end else if (msg_valid) begin
            wait_n    <= wait_n + 1;
            msg_ready <= !slow || wait_n >= 3;
        end
    end
endmodule

// *** verification/test_hotplug_slot_control_status.sv ***
module test_hotplug_slot_control_status;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] OFF = slot_pkg::SLOT_OFF;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd, exp_w;
    logic [3:0]  wstrb;
    logic        awready, wready, bvalid, arready, rvalid, slow;
    logic [1:0]  bresp, rresp, resp;
    logic        attn_button_pressed, power_fault_detected, latch_open;
    logic        card_present, slot_implemented, link_active;
    logic        power_off, hotplug_irq, msg_valid, msg_ready, latch_ctl;
    logic [2:0]  msg_code;
    int          num_errors, compares;
    int          evb [5] = '{16, 17, 18, 19, 24};

    hotplug_slot_control_status #(.AW(8)) i_dut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .attn_button_pressed,
        .power_fault_detected, .latch_open, .card_present,
        .slot_implemented, .link_active, .power_off,
        .electromechanical_latch_control(latch_ctl), .hotplug_irq,
        .msg_valid, .msg_code, .msg_ready
    );
    slot_partner i_slot (.aclk, .msg_valid, .msg_code, .msg_ready, .slow);

    initial begin
        aclk = 1'h0;
        forever #4 aclk = ~aclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time,
                     got, exp);
        end
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [3:0] s);
        logic a_ok;
        logic w_ok;
        int   n;
        a_ok = 1'h0;
        w_ok = 1'h0;
        n = 0;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'h1;
        wdata   <= d;
        wstrb   <= s;
        wvalid  <= 1'h1;
        bready  <= !slow;
        while (!(a_ok && w_ok) && n < 50) begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) begin
                a_ok = 1'h1;
                awvalid <= 1'h0;
            end
            if (wvalid && wready) begin
                w_ok = 1'h1;
                wvalid <= 1'h0;
            end
        end
        do begin
            @(posedge aclk);
            n++;
            if (bvalid && !bready)
                bready <= 1'h1;
        end while (!(bvalid && bready) && n < 50);
        resp = bresp;
        bready <= 1'h0;
        check(32'(n >= 50), 32'h0);
        if (n >= 50)
            end_sim;
    endtask

    task automatic axi_read(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= !slow;
        do begin
            @(posedge aclk);
            n++;
        end while (!arready && n < 50);
        arvalid <= 1'h0;
        do begin
            @(posedge aclk);
            n++;
            if (rvalid && !rready)
                rready <= 1'h1;
        end while (!(rvalid && rready) && n < 50);
        rd = rdata;
        resp = rresp;
        rready <= 1'h0;
        check(32'(n >= 50), 32'h0);
        if (n >= 50)
            end_sim;
    endtask

    // Both indicator fields were written with blink
    task automatic check_msgs;
        int n;
        n = 0;
        while (i_slot.codes.size() < 2 && n < 100) begin
            @(posedge aclk);
            n++;
        end
        check({29'h0, i_slot.codes.pop_front()}, 32'h2);
        check({29'h0, i_slot.codes.pop_front()}, 32'h6);
    endtask

    task automatic end_sim;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #200000;
        num_errors++;
        end_sim;
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, slow} = 7'h0;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        {attn_button_pressed, power_fault_detected, latch_open} = 3'h0;
        {card_present, link_active} = 2'h0;
        slot_implemented = 1'h1;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        axi_read(OFF);
        check(rd, 32'h0000_01C0);
        check({29'h0, latch_ctl, power_off, hotplug_irq}, 32'h0);
        axi_read(8'hDC);
        check({rd[29:0], resp}, {30'h0, slot_pkg::RESP_SLVERR});
        axi_write(8'hDC, 32'hFFFF_FFFF, 4'hF);
        check({30'h0, resp}, {30'h0, slot_pkg::RESP_SLVERR});
        axi_write(OFF, 32'h0000_16BF, 4'h3);
        check_msgs();
        repeat (4) @(posedge aclk);
        axi_read(OFF);
        check(rd, 32'h0010_16BF);
        check({30'h0, power_off, hotplug_irq}, 32'h3);
        axi_write(OFF, 32'h0010_0000, 4'h4);
        repeat (3) @(posedge aclk);
        check({31'h0, hotplug_irq}, 32'h0);
        for (int k = 0; k < 5; k++) begin
            case (k)
                0: attn_button_pressed <= 1'h1;
                1: power_fault_detected <= 1'h1;
                2: latch_open <= 1'h1;
                3: card_present <= 1'h1;
                default: link_active <= 1'h1;
            endcase
            @(posedge aclk);
            attn_button_pressed  <= 1'h0;
            power_fault_detected <= 1'h0;
            repeat (3) @(posedge aclk);
            axi_read(OFF);
            exp_w = 32'h0000_16BF | (32'h1 << evb[k])
                    | {9'h0, card_present, latch_open, 21'h0}
                    | (k > 1 ? 32'h0004_0000 : 32'h0);
            check(rd, exp_w);
            check({31'h0, hotplug_irq}, 32'h1);
            axi_write(OFF, 32'h011F_0000, 4'hC);
            repeat (3) @(posedge aclk);
            check(32'(hotplug_irq), 32'(k > 1));
        end
        slow <= 1'h1;
        axi_write(OFF, 32'h0000_1E9F, 4'h3);
        check_msgs();
        repeat (4) @(posedge aclk);
        check({29'h0, latch_ctl, power_off, hotplug_irq}, 32'h6);
        card_present     <= 1'h0;
        slot_implemented <= 1'h0;
        repeat (3) @(posedge aclk);
        axi_read(OFF);
        check(rd & 32'h0064_0000, 32'h0064_0000);
        end_sim;
    end
endmodule
